// ### shared/sst_pkg.sv
`default_nettype none
// =====================================================================
// soft-start timeout constants
package sst_pkg;
  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_RAMP = 8'h61;
  localparam logic [7:0] CMD_LIMIT = 8'h62;
  localparam logic [7:0] CMD_ACTION = 8'h63;
  localparam logic [7:0] READ_UNMAPPED = 8'hFF;
  // linear word fields
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam logic [4:0] RAMP_EXP = 5'h1E;
  localparam logic [4:0] LIMIT_EXP = 5'h1F;
  localparam logic [10:0] RAMP_MAN_MAX = 11'h07F;
  localparam logic [6:0] RAMP_MAN_MIN = 7'h02;
  localparam logic [10:0] LIMIT_MAN_MAX = 11'h0FE;
  // action byte fields
  localparam int MODE_LSB = 6;
  localparam int RETRY_LSB = 3;
  localparam logic [1:0] MODE_IGNORE = 2'h0;
  localparam logic [1:0] MODE_DELAY = 2'h1;
  localparam logic [1:0] MODE_SHUT = 2'h2;
  localparam logic [1:0] MODE_BAD = 2'h3;
  localparam logic [2:0] RETRY_LATCH = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // reset values, replaced by nvm or strap right after reset
  localparam logic [15:0] RAMP_RST = 16'hF002;
  localparam logic [15:0] LIMIT_RST = 16'hF800;
  localparam logic [7:0] ACTION_RST = 8'h00;
  // timing: the sequencer counts in quarter-millisecond ticks
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 250000;
  localparam int MS_NS = 1000000;
  localparam int QMS_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = MS_NS / TICK_NS;
  localparam int TICKS_PER_HALF_MS = TICKS_PER_MS / 2;
  // thresholds as fractions of the target
  localparam int PASS_NUM = 17;
  localparam int PASS_DEN = 20;
  localparam int FAIL_NUM = 7;
  localparam int FAIL_DEN = 8;
  // link
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h24;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_DELAY = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b011,
    ST_HICCUP = 3'b100,
    ST_LATCH = 3'b101
  } sst_state_type;
endpackage
`default_nettype wire

// ### logic/sst_link.sv
`default_nettype none
// =====================================================================
// two-wire byte slave, pins sampled on the system clock
module sst_link #(
  parameter logic [6:0] DEV_ADDR = sst_pkg::DEV_ADDR_DEF
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  // byte side
  output logic start_out,
  output logic stop_out,
  output logic wr_out,
  output logic [7:0] wr_data_out,
  output logic rd_req_out,
  input wire logic [7:0] tx_data_in
);
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic active_reg, addr_ph_reg, rd_reg, ack_ph_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
    end
  end

  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire byte_done = cnt_reg == sst_pkg::BITS_PER_BYTE;
  wire addr_hit = sh_reg[7:1] == DEV_ADDR;

  // =====================================================================
  // bit engine
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_reg <= 1'b0;
      addr_ph_reg <= 1'b0;
      rd_reg <= 1'b0;
      ack_ph_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      sda_out <= 1'b0;
      sda_oe_b_out <= 1'b1;
      start_out <= 1'b0;
      stop_out <= 1'b0;
      wr_out <= 1'b0;
      wr_data_out <= 8'h00;
      rd_req_out <= 1'b0;
    end else begin
      start_out <= start_det;
      stop_out <= stop_det;
      wr_out <= 1'b0;
      rd_req_out <= 1'b0;
      if (start_det) begin
        active_reg <= 1'b1;
        addr_ph_reg <= 1'b1;
        rd_reg <= 1'b0;
        ack_ph_reg <= 1'b0;
        cnt_reg <= 4'h0;
        sda_oe_b_out <= 1'b1;
      end else if (stop_det) begin
        active_reg <= 1'b0;
        sda_oe_b_out <= 1'b1;
      end else if (active_reg && scl_rise) begin
        if (!ack_ph_reg) begin
          cnt_reg <= cnt_reg + 4'h1;
          if (!rd_reg) sh_reg <= {sh_reg[6:0], sda_s2};
        end else if (rd_reg && sda_s2 && !addr_ph_reg) begin
          // master refused the byte: stay off the wire until the next start
          active_reg <= 1'b0;
        end
      end else if (active_reg && scl_fall) begin
        if (ack_ph_reg) begin
          ack_ph_reg <= 1'b0;
          cnt_reg <= 4'h0;
          sh_reg <= tx_data_in;
          sda_oe_b_out <= rd_reg ? tx_data_in[7] : 1'b1;
        end else if (byte_done) begin
          ack_ph_reg <= 1'b1;
          if (addr_ph_reg) begin
            addr_ph_reg <= 1'b0;
            active_reg <= addr_hit;
            sda_oe_b_out <= ~addr_hit;
            rd_reg <= sh_reg[0];
            rd_req_out <= addr_hit & sh_reg[0];
          end else if (rd_reg) begin
            // fetch the next byte early; it is loaded at the ack fall
            sda_oe_b_out <= 1'b1;
            rd_req_out <= 1'b1;
          end else begin
            sda_oe_b_out <= 1'b0;
            wr_out <= 1'b1;
            wr_data_out <= sh_reg;
          end
        end else if (rd_reg) begin
          sh_reg <= {sh_reg[6:0], 1'b1};
          sda_oe_b_out <= sh_reg[6];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/sst_top.sv
`default_nettype none
// Function
// - reference ramps to target in the ramp time, independent of target
// - ramp time accepts 0 to 31.75 ms in 0.25 ms steps
// - ramp settings under 0.5 ms run as 0.5 ms
// - out-of-range ramp write is invalid data, flagged and alerted
// - timeout window starts after turn-on delay, ends at 85 percent
// - on expiry last sample below 87.5 percent of target is a fault
// - fault may reflect a sample up to 2 ms before expiry
// - timeout limit accepts 0 to 127 ms in 0.5 ms steps
// - a zero timeout limit disables supervision
// - undervoltage detection enabled only at ramp end
// - fault sets summary, word vout and timeout bits and alerts on the same clock
// - mode: ignore, delay then shut, shut now, 11 invalid
// - retry 0 latches off, 1 to 6 bounds restarts after hiccup
// - retry 7 restarts forever until off or success
// - delay n gives n ms hold and hiccup of max(n,1) ramps
// - invalid action byte is flagged and alerted
// - ramp default from nvm or strap, writes apply at once
// - turn-on delay 0 to 127.5 ms in 0.5 ms steps
module sst_top #(
  parameter int QMS_CYCLES = sst_pkg::QMS_CYCLES_DEF,
  parameter logic [6:0] DEV_ADDR = sst_pkg::DEV_ADDR_DEF
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  output logic alert_out,
  output logic alert_oe_b_out,
  // start-up defaults
  input wire logic nvm_valid_in,
  input wire logic [15:0] nvm_ramp_in,
  input wire logic [15:0] strap_ramp_in,
  input wire logic [15:0] nvm_limit_in,
  input wire logic [7:0] nvm_action_in,
  // sequencing
  input wire logic on_cmd_in,
  input wire logic [7:0] ton_delay_in,
  input wire logic [15:0] vout_command_in,
  input wire logic [15:0] vout_sample_in,
  input wire logic vout_sample_valid_in,
  // converter and status
  output logic power_on_out,
  output logic [15:0] ref_dac_out,
  output logic uv_enable_out,
  output logic status_nota_out,
  output logic status_word_vout_out,
  output logic status_vout_timeout_out,
  output logic status_cml_data_out
);
  localparam int DIV_W = $clog2(QMS_CYCLES);
  localparam int EXP_LSB_C = sst_pkg::EXP_LSB;
  localparam int MAN_MSB_C = sst_pkg::MAN_MSB;
  localparam int MODE_LSB_C = sst_pkg::MODE_LSB;
  localparam int RETRY_LSB_C = sst_pkg::RETRY_LSB;

  logic lk_start, lk_stop, lk_wr, lk_rd_req;
  logic [7:0] lk_wr_data;
  logic [7:0] tx_reg;

  sst_link #(.DEV_ADDR(DEV_ADDR)) u_link (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_b_out(sda_oe_b_out),
    .start_out(lk_start),
    .stop_out(lk_stop),
    .wr_out(lk_wr),
    .wr_data_out(lk_wr_data),
    .rd_req_out(lk_rd_req),
    .tx_data_in(tx_reg)
  );

  // =====================================================================
  // command registers
  logic [15:0] ramp_reg, limit_reg;
  logic [7:0] action_reg;
  logic init_done_reg;
  logic [7:0] cmd_reg, lo_reg, hi_reg;
  logic [1:0] idx_reg;
  logic wr_pend_reg;
  logic rd_idx_reg;

  wire commit = lk_stop & wr_pend_reg;
  wire [15:0] wr_word = {hi_reg, lo_reg};
  wire word_len = idx_reg == 2'h3;
  wire byte_len = idx_reg == 2'h2;
  wire ramp_ok = wr_word[15:EXP_LSB_C] == sst_pkg::RAMP_EXP &&
    wr_word[MAN_MSB_C:0] <= sst_pkg::RAMP_MAN_MAX;
  wire limit_ok = wr_word[15:EXP_LSB_C] == sst_pkg::LIMIT_EXP &&
    wr_word[MAN_MSB_C:0] <= sst_pkg::LIMIT_MAN_MAX;
  wire action_ok = lo_reg[7:MODE_LSB_C] != sst_pkg::MODE_BAD;
  wire wr_ramp = commit & word_len & cmd_reg == sst_pkg::CMD_RAMP;
  wire wr_limit = commit & word_len & cmd_reg == sst_pkg::CMD_LIMIT;
  wire wr_action = commit & byte_len & cmd_reg == sst_pkg::CMD_ACTION;
  wire wr_clear = commit & idx_reg == 2'h1 &
    cmd_reg == sst_pkg::CMD_CLEAR_FAULTS;
  wire bad_data = (wr_ramp & ~ramp_ok) |
    (wr_limit & ~limit_ok) |
    (wr_action & ~action_ok);

  wire [15:0] rd_word = cmd_reg == sst_pkg::CMD_RAMP ? ramp_reg :
    cmd_reg == sst_pkg::CMD_LIMIT ? limit_reg :
    cmd_reg == sst_pkg::CMD_ACTION ? {8'h00, action_reg} :
    {2{sst_pkg::READ_UNMAPPED}};
  wire [7:0] rd_byte = rd_idx_reg ? rd_word[15:8] : rd_word[7:0];

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_reg <= 8'h00;
      lo_reg <= 8'h00;
      hi_reg <= 8'h00;
      idx_reg <= 2'h0;
      wr_pend_reg <= 1'b0;
      rd_idx_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else begin
      if (lk_start || lk_stop) begin
        idx_reg <= 2'h0;
        wr_pend_reg <= 1'b0;
        rd_idx_reg <= 1'b0;
      end else if (lk_wr) begin
        wr_pend_reg <= 1'b1;
        if (idx_reg != 2'h3) idx_reg <= idx_reg + 2'h1;
        if (idx_reg == 2'h0) cmd_reg <= lk_wr_data;
        if (idx_reg == 2'h1) lo_reg <= lk_wr_data;
        if (idx_reg == 2'h2) hi_reg <= lk_wr_data;
      end else if (lk_rd_req) begin
        tx_reg <= rd_byte;
        rd_idx_reg <= 1'b1;
      end
    end
  end

  // defaults are taken one clock after reset release, never at reset
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      init_done_reg <= 1'b0;
      ramp_reg <= sst_pkg::RAMP_RST;
      limit_reg <= sst_pkg::LIMIT_RST;
      action_reg <= sst_pkg::ACTION_RST;
    end else if (!init_done_reg) begin
      init_done_reg <= 1'b1;
      ramp_reg <= nvm_valid_in ? nvm_ramp_in : strap_ramp_in;
      limit_reg <= nvm_limit_in;
      action_reg <= nvm_action_in;
    end else begin
      if (wr_ramp && ramp_ok) ramp_reg <= wr_word;
      if (wr_limit && limit_ok) limit_reg <= wr_word;
      if (wr_action && action_ok) action_reg <= lo_reg;
    end
  end

  // =====================================================================
  // derived timing, all in quarter-millisecond ticks
  wire [6:0] ramp_man = ramp_reg[6:0];
  wire [6:0] ramp_ticks = ramp_man < sst_pkg::RAMP_MAN_MIN ?
    sst_pkg::RAMP_MAN_MIN : ramp_man;
  wire [8:0] limit_ticks = {limit_reg[7:0], 1'b0};
  wire [1:0] act_mode = action_reg[7:MODE_LSB_C];
  wire [2:0] act_retry = action_reg[MODE_LSB_C-1:RETRY_LSB_C];
  wire [2:0] act_dly = action_reg[RETRY_LSB_C-1:0];
  wire [4:0] hold_ticks = {act_dly, 2'h0};
  wire [2:0] hic_mult = act_dly == 3'h0 ? 3'h1 : act_dly;
  wire [9:0] hiccup_ticks = 10'(hic_mult) * 10'(ramp_ticks);
  wire [8:0] delay_ticks = {ton_delay_in, 1'b0};

  logic [DIV_W-1:0] div_reg;
  wire tick = div_reg == DIV_W'(QMS_CYCLES - 1);

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) div_reg <= '0;
    else div_reg <= tick ? '0 : div_reg + DIV_W'(1);
  end

  // =====================================================================
  // telemetry compare
  logic [15:0] sample_reg;
  logic on_s1, on_s2;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sample_reg <= 16'h0000;
      on_s1 <= 1'b0;
      on_s2 <= 1'b0;
    end else begin
      if (vout_sample_valid_in) sample_reg <= vout_sample_in;
      on_s1 <= on_cmd_in;
      on_s2 <= on_s1;
    end
  end

  // the sample lags the output, so a fault may be judged on an old value
  wire below_fail = 22'(sample_reg) * 22'(sst_pkg::FAIL_DEN) <
    22'(vout_command_in) * 22'(sst_pkg::FAIL_NUM);
  wire reached = 22'(sample_reg) * 22'(sst_pkg::PASS_DEN) >=
    22'(vout_command_in) * 22'(sst_pkg::PASS_NUM);

  // =====================================================================
  // sequencer
  typedef sst_pkg::sst_state_type sst_state_type_w;
  sst_state_type_w st_reg, st_next;
  logic [9:0] tmr_reg;
  logic [2:0] retry_reg;
  logic sup_reg;
  logic [8:0] tmo_reg;
  logic ramp_busy_reg;
  logic [6:0] ramp_cnt_reg;
  logic [17:0] acc_reg;

  wire expire = sup_reg & tick & (tmo_reg + 9'h1 == limit_ticks);
  wire fault = expire & below_fail;
  wire can_retry = act_retry != sst_pkg::RETRY_LATCH &&
    (act_retry == sst_pkg::RETRY_FOREVER ||
    retry_reg < act_retry);
  wire [2:0] shut_st = can_retry ? sst_pkg::ST_HICCUP : sst_pkg::ST_LATCH;
  wire running = st_reg == sst_pkg::ST_RUN || st_reg == sst_pkg::ST_HOLD;
  wire delay_done = tmr_reg[8:0] >= delay_ticks;
  wire hold_done = tmr_reg[4:0] >= hold_ticks;
  wire hic_done = tmr_reg >= hiccup_ticks;
  wire start_run = st_reg == sst_pkg::ST_DELAY && delay_done;

  always_comb begin
    st_next = st_reg;
    if (!on_s2) begin
      st_next = sst_pkg::ST_OFF;
    end else begin
      unique case (st_reg)
        sst_pkg::ST_OFF: st_next = sst_pkg::ST_DELAY;
        sst_pkg::ST_DELAY: if (delay_done) st_next = sst_pkg::ST_RUN;
        sst_pkg::ST_RUN: begin
          if (fault && act_mode == sst_pkg::MODE_DELAY)
            st_next = sst_pkg::ST_HOLD;
          else if (fault && act_mode == sst_pkg::MODE_SHUT)
            st_next = sst_state_type_w'(shut_st);
        end
        sst_pkg::ST_HOLD: begin
          if (hold_done)
            st_next = below_fail ? sst_state_type_w'(shut_st) :
              sst_pkg::ST_RUN;
        end
        sst_pkg::ST_HICCUP: if (hic_done) st_next = sst_pkg::ST_DELAY;
        sst_pkg::ST_LATCH: st_next = sst_pkg::ST_LATCH;
        default: st_next = sst_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= sst_pkg::ST_OFF;
      tmr_reg <= 10'h000;
      retry_reg <= 3'h0;
    end else begin
      st_reg <= st_next;
      if (st_next != st_reg) tmr_reg <= 10'h000;
      else if (tick && tmr_reg != 10'h3FF) tmr_reg <= tmr_reg + 10'h001;
      if (st_next == sst_pkg::ST_OFF || (sup_reg && reached))
        retry_reg <= 3'h0;
      else if (st_reg == sst_pkg::ST_HICCUP && hic_done &&
        retry_reg != sst_pkg::RETRY_FOREVER)
        retry_reg <= retry_reg + 3'h1;
    end
  end

  // timeout window opens when the turn-on delay ends
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sup_reg <= 1'b0;
      tmo_reg <= 9'h000;
    end else if (start_run) begin
      sup_reg <= limit_ticks != 9'h000;
      tmo_reg <= 9'h000;
    end else if (!running || reached || expire) begin
      sup_reg <= 1'b0;
    end else if (sup_reg && tick) begin
      tmo_reg <= tmo_reg + 9'h001;
    end
  end

  // ramp: each tick banks the target, each clock pays one code per
  // ramp-tick of credit, so the slope scales with the target
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ramp_busy_reg <= 1'b0;
      ramp_cnt_reg <= 7'h00;
      acc_reg <= 18'h00000;
      ref_dac_out <= 16'h0000;
    end else if (start_run) begin
      ramp_busy_reg <= 1'b1;
      ramp_cnt_reg <= 7'h00;
      acc_reg <= 18'h00000;
      ref_dac_out <= 16'h0000;
    end else if (!running) begin
      ramp_busy_reg <= 1'b0;
      ref_dac_out <= 16'h0000;
    end else if (ramp_busy_reg && tick) begin
      ramp_cnt_reg <= ramp_cnt_reg + 7'h01;
      acc_reg <= acc_reg + 18'(vout_command_in);
      if (ramp_cnt_reg + 7'h01 >= ramp_ticks) begin
        ramp_busy_reg <= 1'b0;
        ref_dac_out <= vout_command_in;
      end
    end else if (ramp_busy_reg && acc_reg >= 18'(ramp_ticks)) begin
      acc_reg <= acc_reg - 18'(ramp_ticks);
      if (ref_dac_out < vout_command_in)
        ref_dac_out <= ref_dac_out + 16'h0001;
    end else if (!ramp_busy_reg) begin
      ref_dac_out <= vout_command_in;
    end
  end

  // =====================================================================
  // status flags: a new event wins over a clear in the same cycle
  wire any_flag = status_nota_out | status_cml_data_out;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_nota_out <= 1'b0;
      status_word_vout_out <= 1'b0;
      status_vout_timeout_out <= 1'b0;
      status_cml_data_out <= 1'b0;
      alert_out <= 1'b0;
      alert_oe_b_out <= 1'b1;
      power_on_out <= 1'b0;
      uv_enable_out <= 1'b0;
    end else begin
      if (fault) begin
        status_nota_out <= 1'b1;
        status_word_vout_out <= 1'b1;
        status_vout_timeout_out <= 1'b1;
      end else if (wr_clear) begin
        status_nota_out <= 1'b0;
        status_word_vout_out <= 1'b0;
        status_vout_timeout_out <= 1'b0;
      end
      if (bad_data) status_cml_data_out <= 1'b1;
      else if (wr_clear) status_cml_data_out <= 1'b0;
      alert_oe_b_out <= ~(any_flag | fault | bad_data);
      power_on_out <= running;
      uv_enable_out <= running & ~ramp_busy_reg;
    end
  end
endmodule
`default_nettype wire

// ### testbench/sst_top_asserts.sv
`default_nettype none
// =====================================================================
// port checker for the start-up sequencer
module sst_top_chk (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // watched ports
  input wire logic alert_oe_b_out,
  input wire logic on_cmd_in,
  input wire logic [15:0] vout_command_in,
  input wire logic [15:0] vout_sample_in,
  input wire logic power_on_out,
  input wire logic [15:0] ref_dac_out,
  input wire logic uv_enable_out,
  input wire logic status_nota_out,
  input wire logic status_word_vout_out,
  input wire logic status_vout_timeout_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_fault;
    $rose(status_vout_timeout_out);
  endsequence
  sequence s_off_held;
    !on_cmd_in [*6];
  endsequence
  property p_ramp_end;
    $rose(uv_enable_out) |-> ref_dac_out == vout_command_in && power_on_out;
  endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("ramp end wrong");
  property p_dac_cap;
    power_on_out |-> ref_dac_out <= vout_command_in;
  endproperty
  a_dac_cap: assert property (p_dac_cap) else $error("dac over target");
  // the bench holds target and sample steady through a run
  property p_fault_low;
    s_fault |-> 32'(vout_sample_in) * 8 < 32'(vout_command_in) * 7;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault on good vout");
  property p_fault_bits;
    s_fault |-> status_nota_out && status_word_vout_out;
  endproperty
  a_fault_bits: assert property (p_fault_bits) else $error("summary bits");
  property p_fault_alert;
    s_fault |-> ##[0:2] !alert_oe_b_out;
  endproperty
  a_fault_alert: assert property (p_fault_alert) else $error("no alert");
  property p_fault_run;
    s_fault |-> $past(power_on_out, 2);
  endproperty
  a_fault_run: assert property (p_fault_run) else $error("fault while off");
  property p_cmd_off;
    s_off_held |=> !power_on_out;
  endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("on after off");
  property p_uv_off;
    $fell(power_on_out) |=> !uv_enable_out;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("uv left on");
endmodule

bind sst_top sst_top_chk u_sst_top_chk (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .alert_oe_b_out(alert_oe_b_out), .on_cmd_in(on_cmd_in),
  .vout_command_in(vout_command_in), .vout_sample_in(vout_sample_in),
  .power_on_out(power_on_out), .ref_dac_out(ref_dac_out),
  .uv_enable_out(uv_enable_out), .status_nota_out(status_nota_out),
  .status_word_vout_out(status_word_vout_out),
  .status_vout_timeout_out(status_vout_timeout_out));
`default_nettype wire

// ### testbench/sst_host.sv
`default_nettype none
// =====================================================================
// bus host: open drain, 64 ns bus clock
module sst_host (
  // clock
  input wire logic sys_clk_in,
  // bus wire
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // data moves 2 clocks after scl falls so both pins never
  // change in the same synchroniser cycle
  task automatic start();
    w(2);
    sda_low_out = 1'b0;
    w(6);
    scl_out = 1'b1;
    w(8);
    sda_low_out = 1'b1;
    w(8);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    w(2);
    sda_low_out = 1'b1;
    w(6);
    scl_out = 1'b1;
    w(8);
    sda_low_out = 1'b0;
    w(8);
  endtask
  task automatic xfer(input logic b, output logic r);
    w(2);
    sda_low_out = !b;
    w(6);
    scl_out = 1'b1;
    w(8);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, ack);
  endtask
  task automatic rb(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(nack, r);
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none
// =====================================================================
// bench: register access and start-up runs
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] DEV = sst_pkg::DEV_ADDR_DEF;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic on_cmd = 1'b0;
  logic nvm_v = 1'b0;
  logic vsv = 1'b0;
  logic pp = 1'b0;
  logic pu = 1'b0;
  logic [7:0] ton_dly = 8'h00;
  logic [15:0] vcmd = 16'h1000;
  logic [15:0] vsmp = 16'h0000;
  logic [15:0] seed = 16'hDBF8;
  logic [3:0] sc = 4'h0;
  logic scl, sda_low, sda_w, sda_o, sda_oe_b, alert_o, alert_oe_b;
  logic pwr, uv, nota, wvout, tmo, cml, res_b;
  logic [15:0] dac, res;
  logic [15:0] exp_q[$];
  string nm_q[$];
  event got;
  int st = 0;
  int rc = 0;
  int rt = 0;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [23:0] bad[4] = '{24'h61E802, 24'h61F080, 24'h62F8FF, 24'h6300C0};
  logic [23:0] good[3] = '{24'h61F07F, 24'h62F8FE, 24'h6300B8};
  assign sda_w = !(sda_low || !sda_oe_b);
  initial forever #2 sys_clk_in = !sys_clk_in;
  sst_top #(.QMS_CYCLES(50), .DEV_ADDR(DEV)) u_sst_top (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_b_out(sda_oe_b),
    .alert_out(alert_o), .alert_oe_b_out(alert_oe_b),
    .nvm_valid_in(nvm_v), .nvm_ramp_in(16'hF004),
    .strap_ramp_in(16'hF006), .nvm_limit_in(16'hF804),
    .nvm_action_in(8'h80), .on_cmd_in(on_cmd), .ton_delay_in(ton_dly),
    .vout_command_in(vcmd), .vout_sample_in(vsmp),
    .vout_sample_valid_in(vsv), .power_on_out(pwr), .ref_dac_out(dac),
    .uv_enable_out(uv), .status_nota_out(nota),
    .status_word_vout_out(wvout), .status_vout_timeout_out(tmo),
    .status_cml_data_out(cml));
  sst_host u_sst_host (.sys_clk_in(sys_clk_in), .sda_in(sda_w),
    .scl_out(scl), .sda_low_out(sda_low));
  always @(negedge sys_clk_in) begin
    sc <= sc + 4'h1;
    vsv <= (sc == 4'h0);
  end
  always @(posedge sys_clk_in) begin
    pp <= pwr;
    pu <= uv;
    if (pwr && !pp) st <= st + 1;
    rc <= (pwr && !pp) ? 0 : rc + 1;
    if (uv && !pu) rt <= rc;
  end
  initial forever begin
    @(got);
    n_compared++;
    if (res !== exp_q[0]) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm_q[0], exp_q[0], res);
    end
    void'(exp_q.pop_front());
    void'(nm_q.pop_front());
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, v);
    nm_q.push_back(n);
    exp_q.push_back(e);
    res = v;
    -> got;
    #1;
  endtask
  task automatic chb(input string n, input logic e, v);
    chk(n, {15'h0, e}, {15'h0, v});
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
    logic a;
    u_sst_host.start();
    u_sst_host.wb({DEV, 1'b0}, a);
    chb("ack", 1'b0, a);
    u_sst_host.wb(c, a);
    if (n > 0) u_sst_host.wb(d[7:0], a);
    if (n > 1) u_sst_host.wb(d[15:8], a);
    u_sst_host.stop();
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e, m);
    logic a;
    logic [15:0] d;
    u_sst_host.start();
    u_sst_host.wb({DEV, 1'b0}, a);
    u_sst_host.wb(c, a);
    u_sst_host.start();
    u_sst_host.wb({DEV, 1'b1}, a);
    u_sst_host.rb(1'b0, d[7:0]);
    u_sst_host.rb(1'b1, d[15:8]);
    u_sst_host.stop();
    chk("read", e, d & m);
  endtask
  task automatic run(input logic [7:0] a, input logic [15:0] l, r,
      input logic hi, ef, input int es, ep, er);
    wr(8'h61, r, 2);
    wr(8'h62, l, 2);
    wr(8'h63, {8'h00, a}, 1);
    seed = lfsr(seed);
    vcmd = (seed & 16'h3FFF) | 16'h1000;
    vsmp = hi ? vcmd : (vcmd >> 1);
    ton_dly = {6'h00, seed[1:0]};
    st = 0;
    on_cmd = 1'b1;
    repeat (4000) @(negedge sys_clk_in);
    chb("timeout", ef, tmo);
    chk("starts", es[15:0], (st > 4) ? 16'h9 : st[15:0]);
    if (ep < 2) chb("power", ep[0], pwr);
    if (er > 0) chb("rise", 1'b1, rt > er - 49 && rt < er + 4);
    on_cmd = 1'b0;
    repeat (20) @(negedge sys_clk_in);
    chb("off", 1'b0, pwr);
    wr(8'h03, 16'h0, 0);
    chb("cleared", 1'b0, tmo);
    $display("run %h done", a);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (6) @(negedge sys_clk_in);
    chb("sda oe", 1'b1, sda_oe_b);
    chb("alert oe", 1'b1, alert_oe_b);
    rst_b_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    rdc(8'h61, 16'hF006, 16'hFFFF);
    rdc(8'h62, 16'hF804, 16'hFFFF);
    rdc(8'h63, 16'h0080, 16'h00FF);
    rdc(8'h10, 16'hFFFF, 16'hFFFF);
    u_sst_host.start();
    u_sst_host.wb({DEV ^ 7'h01, 1'b0}, res_b);
    u_sst_host.stop();
    chb("foreign ack", 1'b1, res_b);
    foreach (bad[i]) begin
      wr(bad[i][23:16], bad[i][15:0], (bad[i][23:16] == 8'h63) ? 1 : 2);
      chb("cml", 1'b1, cml);
      chb("alert", 1'b0, alert_oe_b);
      wr(8'h03, 16'h0, 0);
      chb("cml clear", 1'b0, cml);
    end
    rdc(8'h61, 16'hF006, 16'hFFFF);
    foreach (good[i]) begin
      wr(good[i][23:16], good[i][15:0], (good[i][23:16] == 8'h63) ? 1 : 2);
      rdc(good[i][23:16], good[i][15:0], (i == 2) ? 16'h00FF : 16'hFFFF);
    end
    $display("register test done");
    run(8'h80, 16'hF804, 16'hF002, 1'b0, 1'b1, 1, 0, 0);
    run(8'h90, 16'hF804, 16'hF002, 1'b0, 1'b1, 3, 0, 0);
    run(8'hB8, 16'hF804, 16'hF002, 1'b0, 1'b1, 9, 2, 0);
    run(8'h00, 16'hF804, 16'hF002, 1'b0, 1'b1, 1, 1, 0);
    run(8'h49, 16'hF804, 16'hF002, 1'b0, 1'b1, 2, 0, 0);
    run(8'h80, 16'hF800, 16'hF002, 1'b0, 1'b0, 1, 1, 0);
    run(8'h80, 16'hF804, 16'hF000, 1'b1, 1'b0, 1, 1, 100);
    run(8'h80, 16'hF804, 16'hF004, 1'b1, 1'b0, 1, 1, 200);
    nvm_v = 1'b1;
    rst_b_in = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    rdc(8'h61, 16'hF004, 16'hFFFF);
    end_of_test();
  end
endmodule
`default_nettype wire
